// file: rtl/lane_cfg_pkg.sv
// Constants, types and register map of the extra-lane enable block
package lane_cfg_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int IDX_W  = 10;
    localparam int LANES  = 8;
    localparam int TEST_W = 4;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_CTRL     = 10'h200;
    localparam logic [IDX_W-1:0] IDX_MODE     = 10'h201;
    localparam logic [IDX_W-1:0] IDX_TEST     = 10'h202;
    localparam logic [IDX_W-1:0] IDX_PWDN     = 10'h203;
    localparam logic [IDX_W-1:0] IDX_STAT_A   = 10'h204;
    localparam logic [IDX_W-1:0] IDX_STAT_B   = 10'h205;
    localparam logic [IDX_W-1:0] IDX_STAT_SYS = 10'h206;
    localparam logic [IDX_W-1:0] IDX_EXTRA_A  = 10'h20A;
    localparam logic [IDX_W-1:0] IDX_EXTRA_B  = 10'h20B;

    // Field positions
    localparam int CTRL_MASTER_EN_BIT = 0;
    localparam int EXTRA_SER_BIT      = 0;
    localparam int PWDN_A_BIT         = 0;
    localparam int PWDN_B_BIT         = 1;
    localparam int SYS_ENABLE_BIT     = 0;

    // Reset values
    localparam logic [7:0] EXTRA_RST = 8'h00;
    localparam logic [7:0] CTRL_RST  = 8'h00;
    localparam logic [7:0] MODE_RST  = 8'h00;
    localparam logic [7:0] PWDN_RST  = 8'h00;
    localparam logic [TEST_W-1:0] TEST_RST = 4'h0;

    // Test pattern codes
    localparam logic [TEST_W-1:0] TEST_NONE_A     = 4'h0;
    localparam logic [TEST_W-1:0] TEST_NONE_B     = 4'h5;
    localparam logic [TEST_W-1:0] TEST_OCTET_RAMP = 4'h4;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RESP = 2'b10
    } apb_state_t;

    typedef struct packed {
        logic [7:0]        extra;
        logic [LANES-1:0]  mode_lanes;
        logic [TEST_W-1:0] test_sel;
        logic              link_down;
        logic              run;
    } link_cfg_t;

    typedef struct packed {
        logic [LANES-1:0]  clock_enable;
        logic [LANES-1:0]  serializer_enable;
        logic [LANES-1:0]  ramp_lanes;
        logic [TEST_W-1:0] extra_pattern;
    } link_out_t;

endpackage

// file: rtl/lane_gate.sv
// Per-link lane clock, serializer and pattern gating
`timescale 1ns/100ps
module lane_gate
    import lane_cfg_pkg::*;
(
    input  lane_cfg_pkg::link_cfg_t cfg,
    output lane_cfg_pkg::link_out_t result
);
    import lane_cfg_pkg::*;

    logic [LANES-1:0] clk_req;
    logic [LANES-1:0] ser_req;
    logic [LANES-1:0] ser_chain;
    logic [LANES-1:0] only_extra;
    logic             ramp_case;
    logic             live;

    // Power-down wins over every extra-lane bit
    assign live = cfg.run & ~cfg.link_down;

    assign clk_req[0] = cfg.mode_lanes[0];
    assign ser_req[0] = cfg.mode_lanes[0];
    assign ser_chain[0] = ser_req[0] & live;

    genvar n;
    generate
        for (n = 1; n < LANES; n++) begin : g_lane
            assign clk_req[n] = cfg.mode_lanes[n] | cfg.extra[n];
            // Extra serializers follow the serializer-enable bit
            assign ser_req[n] = cfg.mode_lanes[n]
                              | (cfg.extra[n] & cfg.extra[EXTRA_SER_BIT]);
            // A serializer stays off unless every lower lane's serializer is on
            assign ser_chain[n] = ser_req[n] & ser_chain[n-1] & live;
        end
    endgenerate

    assign only_extra = cfg.extra & ~cfg.mode_lanes & ~{{(LANES-1){1'b0}}, 1'b1};
    assign ramp_case  = (cfg.test_sel == TEST_NONE_A) | (cfg.test_sel == TEST_NONE_B);

    assign result.clock_enable      = live ? clk_req : '0;
    assign result.serializer_enable = ser_chain;
    assign result.ramp_lanes        = ramp_case ? (only_extra & ser_chain) : '0;
    // Other lanes keep the selected rate and pattern
    assign result.extra_pattern     = ramp_case ? TEST_OCTET_RAMP : cfg.test_sel;

endmodule // lane_gate

// file: rtl/apb_access.sv
// APB handshake, index decode and access checking
`timescale 1ns/100ps
module apb_access
    import lane_cfg_pkg::*;
(
    input  wire logic                     clk,
    input  wire logic                     arst_n,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [ADDR_W-1:0]        paddr,
    input  wire logic [3:0]               pstrb,
    input  wire logic                     write_locked,
    output logic                          pready,
    output logic                          pslverr,
    output logic                          read_take,
    output logic                          write_take,
    output logic [lane_cfg_pkg::IDX_W-1:0] index
);
    import lane_cfg_pkg::*;

    apb_state_t state;
    logic       setup;
    logic       bad;

    function automatic logic index_known(input logic [IDX_W-1:0] i);
        index_known = (i == IDX_CTRL) | (i == IDX_MODE) | (i == IDX_TEST)
                    | (i == IDX_PWDN) | (i == IDX_STAT_A) | (i == IDX_STAT_B)
                    | (i == IDX_STAT_SYS) | (i == IDX_EXTRA_A) | (i == IDX_EXTRA_B);
    endfunction

    function automatic logic index_writable(input logic [IDX_W-1:0] i);
        index_writable = index_known(i) & (i != IDX_STAT_A) & (i != IDX_STAT_B)
                       & (i != IDX_STAT_SYS);
    endfunction

    assign index = paddr[ADDR_W-1:2];
    assign setup = (state == ST_IDLE) & psel & ~penable;

    // Extra-lane writes are refused while the interface master enable is set
    always_comb begin
        bad = (paddr[1:0] != 2'b00) | ~index_known(index);
        if (pwrite) begin
            bad = bad | ~index_writable(index);
            if ((index == IDX_EXTRA_A) | (index == IDX_EXTRA_B)) begin
                bad = bad | write_locked;
            end
        end
    end

    assign read_take  = setup & ~pwrite & ~bad;
    assign write_take = (state == ST_RESP) & psel & penable & pwrite & ~pslverr & pstrb[0];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: state <= setup ? ST_RESP : ST_IDLE;
                ST_RESP: state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup & bad;
        end
    end

endmodule // apb_access

// file: rtl/extra_lane_enable_ctrl.sv
// Extra-lane enable register bank and lane gating for links A and B
//
// Register access over APB was left to the implementer.
`timescale 1ns/100ps
module extra_lane_enable_ctrl
    import lane_cfg_pkg::*;
(
    input  wire logic                             clk,
    input  wire logic                             arst_n,
    input  wire logic                             psel,
    input  wire logic                             penable,
    input  wire logic                             pwrite,
    input  wire logic [lane_cfg_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [lane_cfg_pkg::DATA_W-1:0]  pwdata,
    input  wire logic [3:0]                       pstrb,
    output logic                                  pready,
    output logic [lane_cfg_pkg::DATA_W-1:0]       prdata,
    output logic                                  pslverr,
    input  wire logic [lane_cfg_pkg::LANES-1:0]   mode_lanes_a,
    input  wire logic [lane_cfg_pkg::LANES-1:0]   mode_lanes_b,
    output logic                                  interface_master_enable,
    output logic [7:0]                            interface_mode_select,
    output logic [lane_cfg_pkg::TEST_W-1:0]       test_pattern_select,
    output logic [1:0]                            channel_power_down,
    output logic                                  subsystem_enable,
    output lane_cfg_pkg::link_out_t               lanes_a,
    output lane_cfg_pkg::link_out_t               lanes_b
);
    import lane_cfg_pkg::*;

    logic [7:0]       extra_lane_enable_link_a;
    logic [7:0]       extra_lane_enable_link_b;
    logic             read_take;
    logic             write_take;
    logic [IDX_W-1:0] index;
    logic [7:0]       wbyte;
    logic [7:0]       next_rdata;
    logic             next_subsystem;
    link_cfg_t        cfg_a;
    link_cfg_t        cfg_b;
    link_out_t        next_lanes_a;
    link_out_t        next_lanes_b;

    assign wbyte = pwdata[7:0];

    apb_access u_access (
        .clk          (clk),
        .arst_n       (arst_n),
        .psel         (psel),
        .penable      (penable),
        .pwrite       (pwrite),
        .paddr        (paddr),
        .pstrb        (pstrb),
        .write_locked (interface_master_enable),
        .pready       (pready),
        .pslverr      (pslverr),
        .read_take    (read_take),
        .write_take   (write_take),
        .index        (index)
    );

    // Master enable register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            interface_master_enable <= CTRL_RST[CTRL_MASTER_EN_BIT];
        end else if (write_take && index == IDX_CTRL) begin
            interface_master_enable <= wbyte[CTRL_MASTER_EN_BIT];
        end
    end

    // Interface mode register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            interface_mode_select <= MODE_RST;
        end else if (write_take && index == IDX_MODE) begin
            interface_mode_select <= wbyte;
        end
    end

    // Test pattern register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            test_pattern_select <= TEST_RST;
        end else if (write_take && index == IDX_TEST) begin
            test_pattern_select <= wbyte[TEST_W-1:0];
        end
    end

    // Channel power-down register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            channel_power_down <= PWDN_RST[1:0];
        end else if (write_take && index == IDX_PWDN) begin
            channel_power_down <= wbyte[1:0];
        end
    end

    // Extra-lane register, link A
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            extra_lane_enable_link_a <= EXTRA_RST;
        end else if (write_take && index == IDX_EXTRA_A) begin
            extra_lane_enable_link_a <= wbyte;
        end
    end

    // Extra-lane register, link B
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            extra_lane_enable_link_b <= EXTRA_RST;
        end else if (write_take && index == IDX_EXTRA_B) begin
            extra_lane_enable_link_b <= wbyte;
        end
    end

    // Whole subsystem sleeps when both channels are down
    assign next_subsystem = ~(channel_power_down[PWDN_A_BIT]
                            & channel_power_down[PWDN_B_BIT]);

    // Lanes only run once the interface is enabled
    always_comb begin
        cfg_a.extra      = extra_lane_enable_link_a;
        cfg_a.mode_lanes = mode_lanes_a;
        cfg_a.test_sel   = test_pattern_select;
        cfg_a.link_down  = channel_power_down[PWDN_A_BIT];
        cfg_a.run        = interface_master_enable & next_subsystem;
        cfg_b.extra      = extra_lane_enable_link_b;
        cfg_b.mode_lanes = mode_lanes_b;
        cfg_b.test_sel   = test_pattern_select;
        cfg_b.link_down  = channel_power_down[PWDN_B_BIT];
        cfg_b.run        = interface_master_enable & next_subsystem;
    end

    lane_gate u_gate_a (
        .cfg    (cfg_a),
        .result (next_lanes_a)
    );

    lane_gate u_gate_b (
        .cfg    (cfg_b),
        .result (next_lanes_b)
    );

    // Registered so lane controls never glitch on decode
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lanes_a          <= '0;
            lanes_b          <= '0;
            subsystem_enable <= 1'b0;
        end else begin
            lanes_a          <= next_lanes_a;
            lanes_b          <= next_lanes_b;
            subsystem_enable <= next_subsystem;
        end
    end

    // Status reads show the registered lane state
    always_comb begin
        next_rdata = 8'h00;
        case (index)
            IDX_CTRL:     next_rdata[CTRL_MASTER_EN_BIT] = interface_master_enable;
            IDX_MODE:     next_rdata = interface_mode_select;
            IDX_TEST:     next_rdata[TEST_W-1:0] = test_pattern_select;
            IDX_PWDN:     next_rdata[1:0] = channel_power_down;
            IDX_STAT_A:   next_rdata = lanes_a.serializer_enable;
            IDX_STAT_B:   next_rdata = lanes_b.serializer_enable;
            IDX_STAT_SYS: next_rdata[SYS_ENABLE_BIT] = subsystem_enable;
            IDX_EXTRA_A:  next_rdata = extra_lane_enable_link_a;
            IDX_EXTRA_B:  next_rdata = extra_lane_enable_link_b;
            default:      next_rdata = 8'h00;
        endcase
    end

    // Read data held until the setup of the next access; errors read zero
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= '0;
        end else if (read_take) begin
            prdata <= {24'h000000, next_rdata};
        end else if (psel && !penable) begin
            prdata <= '0;
        end
    end

endmodule // extra_lane_enable_ctrl

// file: tb/lane_rx_model.sv
// Far-end receiver model: counts lanes that really serialize
`timescale 1ns/100ps
module lane_rx_model
    import lane_cfg_pkg::*;
(
    input wire logic                      clk,
    input wire logic                      arst_n,
    input wire lane_cfg_pkg::link_out_t   lanes_a,
    input wire lane_cfg_pkg::link_out_t   lanes_b,
    output logic [3:0]                    live_a,
    output logic [3:0]                    live_b
);
    // A lane is live only with clock and serializer both on
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            live_a <= 4'h0;
            live_b <= 4'h0;
        end else begin
            live_a <= 4'($countones(lanes_a.clock_enable & lanes_a.serializer_enable));
            live_b <= 4'($countones(lanes_b.clock_enable & lanes_b.serializer_enable));
        end
    end
endmodule // lane_rx_model

// file: tb/extra_lane_enable_ctrl_monitor.sv
// Concurrent checks on the ports of the extra-lane enable block
`timescale 1ns/100ps
module extra_lane_enable_ctrl_monitor
    import lane_cfg_pkg::*;
(
    input wire logic                            clk,
    input wire logic                            arst_n,
    input wire logic                            psel,
    input wire logic                            penable,
    input wire logic                            pready,
    input wire logic                            pslverr,
    input wire logic [lane_cfg_pkg::LANES-1:0]  mode_lanes_a,
    input wire logic                            interface_master_enable,
    input wire logic [lane_cfg_pkg::TEST_W-1:0] test_pattern_select,
    input wire logic [1:0]                      channel_power_down,
    input wire logic                            subsystem_enable,
    input wire lane_cfg_pkg::link_out_t         lanes_a,
    input wire lane_cfg_pkg::link_out_t         lanes_b
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready not one pulse after setup");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_pd_link_a: assert property (channel_power_down[0] |=> lanes_a[27:4] == 24'h0)
        else $error("link A active while powered down");
    a_pd_link_b: assert property (channel_power_down[1] |=> lanes_b[27:4] == 24'h0)
        else $error("link B active while powered down");
    a_sys_down: assert property (&channel_power_down |=> !subsystem_enable)
        else $error("subsystem up with both channels down");
    a_ser_chain: assert property (((lanes_a.serializer_enable >> 1) & ~lanes_a.serializer_enable) == 8'h00)
        else $error("serializer on above a gap");
    a_ser_clock: assert property ((lanes_a.serializer_enable & ~lanes_a.clock_enable) == 8'h00)
        else $error("serializer on without lane clock");
    a_ramp_extra: assert property ((lanes_a.ramp_lanes & ~lanes_a.serializer_enable) == 8'h00
        && !lanes_a.ramp_lanes[0])
        else $error("ramp on a lane not serializing");
    a_mode_kept: assert property (interface_master_enable && !channel_power_down[0]
        |=> (lanes_a.clock_enable & $past(mode_lanes_a)) == $past(mode_lanes_a))
        else $error("mode lane clock missing");
    // Sampled reset keeps the release edge out; lanes are still zero there
    a_pattern_map: assert property (arst_n |=> lanes_a.extra_pattern ==
        (($past(test_pattern_select) inside {4'h0, 4'h5}) ? 4'h4 : $past(test_pattern_select)))
        else $error("extra pattern wrong");
endmodule // extra_lane_enable_ctrl_monitor

// file: tb/tb.sv
// Self-checking bench for the extra-lane enable block
`timescale 1ns/100ps
module tb;
    import lane_cfg_pkg::*;
    typedef struct packed {
        logic [7:0] ex, md;
        logic [3:0] ts;
        logic [7:0] ck, sr, rp;
        logic [3:0] pt;
    } row_t;
    logic                clk, arst_n, psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0]   paddr;
    logic [DATA_W-1:0]   pwdata, prdata, rd;
    logic [3:0]          pstrb, live_a, live_b;
    logic [LANES-1:0]    mode_lanes_a, mode_lanes_b;
    logic                interface_master_enable, subsystem_enable, er;
    logic [7:0]          interface_mode_select;
    logic [TEST_W-1:0]   test_pattern_select;
    logic [1:0]          channel_power_down, mis;
    link_out_t           lanes_a, lanes_b;
    int                  n_mismatch, checks, cyc;
    row_t rows[7] = '{
        '{8'h03, 8'h01, 4'h0, 8'h03, 8'h03, 8'h02, 4'h4},
        '{8'h02, 8'h01, 4'h5, 8'h03, 8'h01, 8'h00, 4'h4},
        '{8'h09, 8'h03, 4'h0, 8'h0B, 8'h03, 8'h00, 4'h4},
        '{8'hFF, 8'h01, 4'h4, 8'hFF, 8'hFF, 8'h00, 4'h4},
        '{8'h0F, 8'h03, 4'h2, 8'h0F, 8'h0F, 8'h00, 4'h2},
        '{8'h0F, 8'h03, 4'h5, 8'h0F, 8'h0F, 8'h0C, 4'h4},
        '{8'h00, 8'h0F, 4'h0, 8'h0F, 8'h0F, 8'h00, 4'h4}};

    extra_lane_enable_ctrl i_extra_lane_enable_ctrl (.clk, .arst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .pready, .prdata, .pslverr, .mode_lanes_a, .mode_lanes_b,
        .interface_master_enable, .interface_mode_select, .test_pattern_select,
        .channel_power_down, .subsystem_enable, .lanes_a, .lanes_b);
    lane_rx_model i_lane_rx_model (.clk, .arst_n, .lanes_a, .lanes_b, .live_a, .live_b);

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [IDX_W-1:0] i, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, mis};
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        // Read before this edge's updates land, so pready is the sampled value
        // Only the bench timeout ends a stuck wait
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            close_out;
        end
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata, mis} = '0;
        {mode_lanes_a, mode_lanes_b} = '0;
        pstrb = 4'hF;
        arst_n = 1'b0;
        repeat (20) @(posedge clk);
        chk("lanes_a rst", 0, lanes_a);
        arst_n <= 1'b1;
        apb(0, IDX_EXTRA_A, 0); chk("extra_a reset", 0, rd);
        chk("subsys rst", 1, subsystem_enable);
        apb(0, IDX_EXTRA_B, 0); chk("extra_b reset", 0, rd);
        apb(1, IDX_EXTRA_A, 8'hA5); apb(0, IDX_EXTRA_A, 0); chk("extra_a rw", 32'hA5, rd);
        apb(1, IDX_EXTRA_B, 8'h5A); apb(0, IDX_EXTRA_B, 0); chk("extra_b rw", 32'h5A, rd);
        foreach (rows[k]) begin
            apb(1, IDX_CTRL, 0);
            apb(1, IDX_EXTRA_A, rows[k].ex);
            chk("extra_a ok", 0, er);
            apb(1, IDX_EXTRA_B, rows[k].ex);
            apb(1, IDX_TEST, {4'h0, rows[k].ts});
            mode_lanes_a <= rows[k].md;
            mode_lanes_b <= rows[k].md;
            apb(1, IDX_CTRL, 1);
            repeat (3) @(posedge clk);
            chk("lanes_a", {rows[k].ck, rows[k].sr, rows[k].rp, rows[k].pt}, lanes_a);
            chk("lanes_b", {rows[k].ck, rows[k].sr, rows[k].rp, rows[k].pt}, lanes_b);
            chk("rx live", $countones(rows[k].sr), live_a);
            chk("rx live b", $countones(rows[k].sr), live_b);
            chk("test out", rows[k].ts, test_pattern_select);
            chk("enable out", 1, interface_master_enable);
        end
        // Device refuses extra-lane writes while the interface runs
        apb(1, IDX_EXTRA_A, 8'h11); chk("locked err", 1, er);
        apb(0, IDX_EXTRA_A, 0); chk("locked value", 0, rd);
        apb(0, IDX_STAT_A, 0);
        chk("stat_a", 8'h0F, rd);
        apb(1, IDX_STAT_A, 8'h00);
        chk("stat ro err", 1, er);
        apb(1, IDX_MODE, 8'h5C);
        apb(0, IDX_MODE, 0);
        chk("mode rd", 32'h5C, rd);
        chk("mode out", 8'h5C, interface_mode_select);
        apb(1, IDX_CTRL, 0); apb(1, IDX_PWDN, 1); apb(1, IDX_CTRL, 1);
        repeat (3) @(posedge clk);
        chk("lanes_a pd", 32'h4, lanes_a);
        chk("lanes_b live", 8'h0F, lanes_b.clock_enable);
        chk("pd out", 2'h1, channel_power_down);
        apb(1, IDX_CTRL, 0); apb(1, IDX_PWDN, 3);
        repeat (3) @(posedge clk);
        chk("subsys down", 0, subsystem_enable);
        apb(1, IDX_PWDN, 0);
        repeat (3) @(posedge clk);
        chk("subsys up", 1, subsystem_enable);
        apb(0, 10'h207, 0); chk("unmapped err", 1, er);
        mis = 2'b01;
        apb(0, IDX_EXTRA_A, 0); chk("misaligned err", 1, er);
        mis = 2'b00;
        // Write without the low strobe is dropped silently
        pstrb <= 4'hE;
        apb(1, IDX_EXTRA_A, 8'h77);
        chk("strobe err", 0, er);
        pstrb <= 4'hF;
        apb(0, IDX_EXTRA_A, 0);
        chk("strobe kept", 0, rd);
        apb(1, IDX_EXTRA_A, 8'h3C);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        apb(0, IDX_EXTRA_A, 0); chk("extra_a rerst", 0, rd);
        close_out;
    end
endmodule // tb

bind extra_lane_enable_ctrl extra_lane_enable_ctrl_monitor i_extra_lane_enable_ctrl_monitor (.clk, .arst_n,
    .psel, .penable, .pready, .pslverr, .mode_lanes_a, .interface_master_enable, .test_pattern_select,
    .channel_power_down, .subsystem_enable, .lanes_a, .lanes_b);
